// [pkg/chan_seq_pkg.sv]
package chan_seq_pkg;
	typedef logic [3:0]  chan_mask_t;
	typedef logic [1:0]  chan_idx_t;
	typedef logic [11:0] code_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_NEXT = 2'b10
	} seq_state_e;
endpackage

// [pkg/chan_seq_regs.svh]
`ifndef CHAN_SEQ_REGS_SVH
`define CHAN_SEQ_REGS_SVH

`define NUM_CHAN        3'h4
`define MASK_RESET      4'h0
`define CODE_WIDTH      12
`define CODE_STEPS      4096
`define CHAN_IDX_W      2
`define CONV_TIME_NS    1650
`define CLK_PERIOD_NS   100
`define CONV_CYCLES     (((`CONV_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define BIPOLAR_MID     12'h800
`define SAMPLE_MAX      12'hFFF

`endif

// [pkg/seq_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface seq_if;
	import chan_seq_pkg::*;
	logic       load;
	chan_mask_t mask;
	logic       advance;
	logic       valid;
	chan_idx_t  chan;
	logic       last;
	modport picker (input load, mask, advance, output valid, chan, last);
	modport ctrl   (output load, mask, advance, input valid, chan, last);
endinterface
`default_nettype wire

// [sim/adc_channel_sequence_select_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_channel_sequence_select_bench;
	import chan_seq_pkg::*;
	localparam code_t TBL [4] = '{12'h000, 12'hFFF, 12'h7FF, 12'h800};
	logic       clk_sys, rst_b, cs_n, rd_n, wr_n, src, start_n;
	logic       busy, hold, conv_strobe;
	chan_mask_t data_q, pins_q, active_mask;
	code_t      sample_raw, result_code;
	code_t      result_uni;
	chan_idx_t  conv_chan;
	int         failures;
	int         samples_checked;

	chan_seq_select #(.BIPOLAR(1'b1)) dut_u (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.data_line_0(data_q[0]), .data_line_1(data_q[1]), .data_line_2(data_q[2]), .data_line_3(data_q[3]),
		.chan1_select_pin(pins_q[0]), .chan2_select_pin(pins_q[1]),
		.chan3_select_pin(pins_q[2]), .chan4_select_pin(pins_q[3]),
		.sw_source_sel(src), .conversion_start_n(start_n), .sample_raw(sample_raw),
		.busy(busy), .hold(hold), .conv_strobe(conv_strobe), .conv_chan(conv_chan),
		.result_code(result_code), .active_mask(active_mask)
	);
	core_model core_u (.clk_sys(clk_sys), .busy(busy), .conv_strobe(conv_strobe), .sample_raw(sample_raw));
	// unipolar variant on the same stimulus, so its timing matches dut_u
	chan_seq_select #(.BIPOLAR(1'b0)) dut_u_uni (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.data_line_0(data_q[0]), .data_line_1(data_q[1]), .data_line_2(data_q[2]), .data_line_3(data_q[3]),
		.chan1_select_pin(pins_q[0]), .chan2_select_pin(pins_q[1]),
		.chan3_select_pin(pins_q[2]), .chan4_select_pin(pins_q[3]),
		.sw_source_sel(src), .conversion_start_n(start_n), .sample_raw(sample_raw),
		.busy(), .hold(), .conv_strobe(), .conv_chan(),
		.result_code(result_uni), .active_mask()
	);

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input chan_mask_t m, input logic rd);
		@(posedge clk_sys);
		cs_n   <= 1'b0;
		wr_n   <= 1'b0;
		rd_n   <= rd;
		data_q <= m;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge clk_sys);
		rd_n   <= 1'b1;
		data_q <= ~m;
	endtask

	task automatic seq(input logic s, input chan_mask_t pins, input chan_mask_t exp);
		int n;
		int k;
		k = 0;
		@(posedge clk_sys);
		src     <= s;
		pins_q  <= pins;
		start_n <= 1'b0;
		@(posedge clk_sys);
		start_n <= 1'b1;
		for (n = 0; n < 4 && busy !== 1'b1; n++)
			step;
		chk(12'(busy), 12'h001);
		chk(12'(hold), 12'h001);
		chk(12'(active_mask), 12'(exp));
		// late changes and a second start must not affect the running sequence
		@(posedge clk_sys);
		src     <= ~s;
		pins_q  <= ~pins;
		start_n <= (exp == 4'h0);
		@(posedge clk_sys);
		start_n <= 1'b1;
		#1;
		for (int c = 0; c < 4; c++) begin
			if (exp[c]) begin
				for (n = 0; n < 40 && conv_strobe !== 1'b1; n++)
					step;
				chk(12'(conv_chan), 12'(c));
				chk(result_code, TBL[k] ^ 12'h800);
				chk(result_uni, TBL[k]);
				k++;
				step;
			end
		end
		repeat (3)
			step;
		chk(12'(busy), 12'h000);
		chk(12'(hold), 12'h000);
		chk(12'(active_mask), 12'(exp));
	endtask

	task automatic finish_test;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		#200000;
		failures++;
		finish_test;
	end

	initial begin
		rst_b   = 1'b0;
		cs_n    = 1'b1;
		rd_n    = 1'b1;
		wr_n    = 1'b1;
		src     = 1'b0;
		start_n = 1'b1;
		data_q  = 4'h0;
		pins_q  = 4'h0;
		repeat (2)
			@(posedge clk_sys);
		rst_b <= 1'b1;
		step;
		chk(12'(busy), 12'h000);
		seq(1'b1, 4'hF, 4'h0);
		seq(1'b0, 4'hD, 4'hD);
		wr(4'hA, 1'b1);
		seq(1'b1, 4'h5, 4'hA);
		wr(4'h1, 1'b0);
		seq(1'b1, 4'h0, 4'hA);
		seq(1'b0, 4'hF, 4'hF);
		wr(4'h0, 1'b1);
		seq(1'b1, 4'hF, 4'h0);
		finish_test;
	end
endmodule
`default_nettype wire

// [sim/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model
	import chan_seq_pkg::*;
(
	// clock and status
	input  wire logic  clk_sys,
	input  wire logic  busy,
	input  wire logic  conv_strobe,
	// sample to block
	output var  code_t sample_raw
);
	// one value per slot; extremes expose a wrong sign flip
	localparam code_t TBL [4] = '{12'h000, 12'hFFF, 12'h7FF, 12'h800};
	logic [1:0] slot_q;
	always_ff @(posedge clk_sys) begin
		if (!busy)
			slot_q <= 2'h0;
		else if (conv_strobe)
			slot_q <= slot_q + 2'h1;
	end
	assign sample_raw = TBL[slot_q];
endmodule
`default_nettype wire

// [src/chan_picker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "chan_seq_regs.svh"
module chan_picker
	import chan_seq_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// sequence port
	seq_if.picker     sq
);
	chan_mask_t pend_q;

	// lowest set bit wins, so order never depends on pick order
	function automatic chan_idx_t lowest(input chan_mask_t m);
		chan_idx_t r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) begin
				r = chan_idx_t'(i);
			end
		end
		return r;
	endfunction

	function automatic chan_mask_t drop_low(input chan_mask_t m);
		return m & (m - 4'h1);
	endfunction

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= `MASK_RESET;
		end else if (sq.load) begin
			pend_q <= sq.mask;
		end else if (sq.advance) begin
			pend_q <= drop_low(pend_q);
		end
	end

	assign sq.valid = |pend_q;
	assign sq.chan  = lowest(pend_q);
	assign sq.last  = (drop_low(pend_q) == `MASK_RESET);

	ascend_order_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sq.advance && !sq.load && sq.valid && !sq.last |=> sq.chan > $past(sq.chan))
		else $error("channel order not ascending");
endmodule
`default_nettype wire

// [src/chan_seq_select.sv]
`timescale 1ns/1ps
`default_nettype none
`include "chan_seq_regs.svh"
module chan_seq_select
	import chan_seq_pkg::*;
#(
	parameter bit BIPOLAR = 1'b1
) (
	// clock and reset
	input  wire logic  clk_sys,
	input  wire logic  rst_b,
	// host bus
	input  wire logic  chip_select_n,
	input  wire logic  read_strobe_n,
	input  wire logic  write_strobe_n,
	input  wire logic  data_line_0,
	input  wire logic  data_line_1,
	input  wire logic  data_line_2,
	input  wire logic  data_line_3,
	// channel selection
	input  wire logic  chan1_select_pin,
	input  wire logic  chan2_select_pin,
	input  wire logic  chan3_select_pin,
	input  wire logic  chan4_select_pin,
	input  wire logic  sw_source_sel,
	input  wire logic  conversion_start_n,
	// sample from converter core, unsigned ground-referenced
	input  wire code_t sample_raw,
	// status and results
	output var  logic  busy,
	output var  logic  hold,
	output var  logic  conv_strobe,
	output var  chan_idx_t conv_chan,
	output var  code_t result_code,
	output var  chan_mask_t active_mask
);
	seq_if sq ();

	chan_mask_t channel_inclusion_mask_q;
	logic       wr_arm_q;
	logic       start_dly_q;
	logic [4:0] cnt_q;
	seq_state_e state_q;
	chan_mask_t pin_mask;
	chan_mask_t mux_mask;
	logic       start_rise;
	logic       wr_window;
	logic       conv_done;

	localparam logic [4:0] CONV_CNT = 5'(`CONV_CYCLES - 1);

	// code shaping: bipolar flips the msb of an offset-binary sample
	function automatic code_t fmt_code(input code_t raw, input bit bip);
		return bip ? (raw ^ `BIPOLAR_MID) : raw;
	endfunction

	assign pin_mask   = {chan4_select_pin, chan3_select_pin, chan2_select_pin, chan1_select_pin};
	assign mux_mask   = sw_source_sel ? channel_inclusion_mask_q : pin_mask;
	assign start_rise = conversion_start_n && !start_dly_q;
	assign wr_window  = read_strobe_n && !chip_select_n && !write_strobe_n;
	assign conv_done  = (state_q == ST_CONV) && (cnt_q == CONV_CNT);

	// write strobe rising edge closes an armed window
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_arm_q <= 1'b0;
		end else begin
			wr_arm_q <= wr_window;
		end
	end

	// last data seen inside the window is what lands; not readable back
	logic [3:0] wr_data_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_data_q <= `MASK_RESET;
		end else if (wr_window) begin
			wr_data_q <= {data_line_3, data_line_2, data_line_1, data_line_0};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			channel_inclusion_mask_q <= `MASK_RESET;
		end else if (wr_arm_q && write_strobe_n) begin
			channel_inclusion_mask_q <= wr_data_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			start_dly_q <= 1'b1;
		end else begin
			start_dly_q <= conversion_start_n;
		end
	end

	// starts during a running sequence are ignored, the latch must not move
	assign sq.load    = start_rise && (state_q == ST_IDLE);
	assign sq.mask    = mux_mask;
	assign sq.advance = conv_done;

	chan_picker u_picker (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.sq      (sq)
	);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (sq.load) begin
						state_q <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					state_q <= sq.valid ? ST_CONV : ST_IDLE;
				end
				ST_CONV: begin
					if (conv_done) begin
						state_q <= sq.last ? ST_IDLE : ST_NEXT;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 5'h0;
		end else if (state_q != ST_CONV) begin
			cnt_q <= 5'h0;
		end else begin
			cnt_q <= cnt_q + 5'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			busy        <= 1'b0;
			hold        <= 1'b0;
			active_mask <= `MASK_RESET;
		end else if (sq.load) begin
			busy        <= 1'b1;
			hold        <= 1'b1;
			active_mask <= mux_mask;
		end else if ((conv_done && sq.last) || (state_q == ST_NEXT && !sq.valid)) begin
			busy <= 1'b0;
			hold <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			conv_strobe <= 1'b0;
			conv_chan   <= 2'h0;
			result_code <= 12'h000;
		end else begin
			conv_strobe <= conv_done;
			if (conv_done) begin
				conv_chan   <= sq.chan;
				result_code <= fmt_code(sample_raw, BIPOLAR);
			end
		end
	end

	busy_on_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sq.load |=> busy && hold)
		else $error("busy not raised at start");

	mask_held_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		busy && $past(busy) |-> $stable(active_mask))
		else $error("latched mask moved mid sequence");

	src_mux_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sq.load && !sw_source_sel |=> active_mask == $past(pin_mask))
		else $error("pin mask not taken");

	reg_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_arm_q && write_strobe_n |=> channel_inclusion_mask_q == $past(wr_data_q))
		else $error("register write lost");

	reg_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!(wr_arm_q && write_strobe_n) |=> $stable(channel_inclusion_mask_q))
		else $error("register changed without write");

	bipolar_code_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		conv_done && BIPOLAR |=> result_code[11] == !$past(sample_raw[11]))
		else $error("bipolar coding wrong");

	unipolar_code_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		conv_done && !BIPOLAR |=> result_code == $past(sample_raw))
		else $error("straight binary coding wrong");

	empty_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sq.load && mux_mask == 4'h0 |=> ##1 !busy)
		else $error("empty sequence did not end");

	// busy and the sequencer live in separate processes, so tie them together
	busy_span_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		busy == (state_q != ST_IDLE))
		else $error("busy does not span the sequence");
endmodule
`default_nettype wire
